/* hw/pmc_params.svh */
// Offsets, field positions, reset values and timing counts of the power mode bank.
// Assumes the including file uses the pmc_pkg types for the register fields.
// Behaviour
// R01 - Timebase select bit 6 makes all timing follow the clock on irq pin one.
// R02 - Noise field bits 5:4: 00 normal, 01 low noise, 10 ultralow, 11 reserved.
// R03 - Bit 3 set puts the device into periodic wake mode.
// R04 - Auto-doze bit 2 acts only with chained or repeat-cycle motion detection.
// R05 - Effective auto-doze enters periodic wake mode whenever inactivity is seen.
// R06 - Run select bits 1:0: 00 standby, 10 measurement, 01 and 11 reserved.
// R07 - Power mode register resets to zero: standby, normal noise, internal clock.
// R08 - Proof force bit 0 drives all three axes while set; resets to zero.
// R09 - Host configures in register order and writes power mode register last.
// R10 - Host should program the activity dwell count above one; this bank holds no dwell count and no frame of the host model writes it.
// R11 - Awake indication on irq pin two runs on without host action.
// R12 - Bit 6 of irq pin two map routes awake status to that pin.
// R13 - Motion switch start writes 0x0a: measurement plus periodic wake.
// R14 - Host never writes reserved codes or nonzero reserved and unused bits.
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH
`define PMC_ADDR_MOTION 8'h27
`define PMC_ADDR_IRQ2_MAP 8'h2b
`define PMC_ADDR_POWER 8'h2d
`define PMC_ADDR_SELF_CHECK 8'h2e
`define PMC_CMD_WRITE 8'h01
`define PMC_CMD_READ 8'h02
`define PMC_RST_POWER 8'h00
`define PMC_RST_SELF_CHECK 8'h00
`define PMC_RST_MOTION 8'h00
`define PMC_RST_IRQ2_MAP 8'h00
`define PMC_MAP_AWAKE_BIT 6
`define PMC_MAP_LOW_BIT 7
`define PMC_PROOF_BIT 0
`define PMC_LINK_HI 5
`define PMC_LINK_LO 4
`define PMC_LINK_CHAINED 2'b01
`define PMC_LINK_REPEAT 2'b11
`define PMC_TICK_NS 1000
`define PMC_CLK_NS 50
`define PMC_TICK_CYC ((`PMC_TICK_NS + `PMC_CLK_NS - 1) / `PMC_CLK_NS)
`endif

/* hw/pmc_pkg.sv */
// Types of the power mode bank: field layout of the power mode register and modes.
// Assumes nothing beyond a SystemVerilog compiler.
package pmc_pkg;
  typedef enum logic [1:0] {
    PMC_NOISE_NORMAL = 2'b00,
    PMC_NOISE_LOW = 2'b01,
    PMC_NOISE_ULTRA = 2'b10,
    PMC_NOISE_RSVD = 2'b11
  } pmc_noise_e;
  typedef enum logic [1:0] {
    PMC_RUN_STANDBY = 2'b00,
    PMC_RUN_RSVD1 = 2'b01,
    PMC_RUN_RUN_SELECT = 2'b10,
    PMC_RUN_RSVD3 = 2'b11
  } pmc_run_e;
  typedef struct packed {
    logic rsvd;
    logic outside_timebase_select;
    pmc_noise_e noise;
    logic periodic_wake_mode;
    logic auto_doze;
    pmc_run_e run_select;
  } pmc_power_s;
  typedef enum logic [1:0] {
    PMC_SP_IDLE = 2'b00,
    PMC_SP_CMD = 2'b01,
    PMC_SP_ADDR = 2'b10,
    PMC_SP_DATA = 2'b11
  } pmc_spi_e;
endpackage

/* hw/pmc_power_mode_bank.sv */
// Power mode and self-check bank with its serial register port.
// Assumes a mode 0 serial host with sclk well below a quarter of clk_sys, and motion
// logic on clk_sys that supplies the inactivity and awake levels.
`include "pmc_params.svh"
module pmc_power_mode_bank (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Serial register port pins
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  // Interrupt pins
  input wire logic irq_pin_one_i,
  output logic irq_pin_two_o,
  output logic irq_pin_two_oe,
  // Motion logic status
  input wire logic inactivity_i,
  input wire logic awake_status_i,
  // Mode outputs to the sensor core
  output logic timebase_tick_o,
  output pmc_pkg::pmc_noise_e noise_mode_o,
  output logic periodic_wake_o,
  output logic run_select_o,
  output logic proof_force_o
);
  import pmc_pkg::*;

  localparam logic [7:0] TICK_LAST = 8'(`PMC_TICK_CYC - 1);

  logic sclk_s1_ff, sclk_s2_ff, sclk_s3_ff;
  logic cs_n_s1_ff, cs_n_s2_ff;
  logic mosi_s1_ff, mosi_s2_ff;
  logic ext_s1_ff, ext_s2_ff, ext_s3_ff;
  logic sclk_rise, sclk_fall, ext_edge, int_tick, wr_en, byte_done, doze_eff;
  logic [7:0] nxt_byte, rd_data;
  logic [7:0] shift_in_ff, cmd_ff, addr_ff, rd_shift_ff, tick_cnt_ff;
  logic [7:0] self_check_ff, motion_ff, irq2_map_ff;
  logic [2:0] bit_cnt_ff;
  logic done_ff, tick_ff;
  pmc_power_s power_ff;
  pmc_spi_e state_ff;

  // Two-stage synchronisers for every pin; third stage only feeds edge detection
  always_ff @(posedge clk_sys)
  begin
    sclk_s1_ff <= spi_sclk;
    sclk_s2_ff <= sclk_s1_ff;
    sclk_s3_ff <= sclk_s2_ff;
    cs_n_s1_ff <= spi_cs_n;
    cs_n_s2_ff <= cs_n_s1_ff;
    mosi_s1_ff <= spi_mosi;
    mosi_s2_ff <= mosi_s1_ff;
    ext_s1_ff <= irq_pin_one_i;
    ext_s2_ff <= ext_s1_ff;
    ext_s3_ff <= ext_s2_ff;
  end

  assign sclk_rise = sclk_s2_ff & ~sclk_s3_ff;
  assign sclk_fall = ~sclk_s2_ff & sclk_s3_ff;
  assign ext_edge = ext_s2_ff & ~ext_s3_ff;
  assign nxt_byte = {shift_in_ff[6:0], mosi_s2_ff};
  assign byte_done = sclk_rise && (bit_cnt_ff == 3'h7);

  // Frame sequencer: command byte, address byte, then one data byte
  always_ff @(posedge clk_sys)
  begin
    if (srst || cs_n_s2_ff)
    begin
      state_ff <= PMC_SP_IDLE;
      bit_cnt_ff <= 3'h0;
      shift_in_ff <= 8'h00;
      cmd_ff <= 8'h00;
      addr_ff <= 8'h00;
      done_ff <= 1'b0;
    end
    else if (state_ff == PMC_SP_IDLE)
    begin
      state_ff <= PMC_SP_CMD;
    end
    else if (sclk_rise)
    begin
      shift_in_ff <= nxt_byte;
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      if (byte_done)
      begin
        case (state_ff)
          PMC_SP_CMD:
          begin
            cmd_ff <= nxt_byte;
            state_ff <= PMC_SP_ADDR;
          end
          PMC_SP_ADDR:
          begin
            addr_ff <= nxt_byte;
            state_ff <= PMC_SP_DATA;
          end
          PMC_SP_DATA: done_ff <= 1'b1; // Bytes past the first data byte are ignored
          default: state_ff <= PMC_SP_IDLE;
        endcase
      end
    end
  end

  // One write per frame, on the last bit of the data byte
  assign wr_en = byte_done && (state_ff == PMC_SP_DATA) && (cmd_ff == `PMC_CMD_WRITE) && !done_ff;

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    case (nxt_byte)
      `PMC_ADDR_MOTION: rd_data = motion_ff;
      `PMC_ADDR_IRQ2_MAP: rd_data = irq2_map_ff;
      `PMC_ADDR_POWER: rd_data = power_ff;
      `PMC_ADDR_SELF_CHECK: rd_data = self_check_ff;
      default: rd_data = 8'h00;
    endcase
  end

  // Read shifter: loaded as the address completes, shifted on later falling edges
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      rd_shift_ff <= 8'h00;
    else if (byte_done && state_ff == PMC_SP_ADDR)
      rd_shift_ff <= rd_data;
    else if (sclk_fall && state_ff == PMC_SP_DATA && bit_cnt_ff != 3'h0)
      rd_shift_ff <= {rd_shift_ff[6:0], 1'b0};
  end

  assign spi_miso = rd_shift_ff[7];
  assign spi_miso_oe = !cs_n_s2_ff && (state_ff == PMC_SP_DATA) && (cmd_ff == `PMC_CMD_READ) && !done_ff;

  // R07 power mode register reset
  // Reserved codes are stored as written; keeping them out is up to the host
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      power_ff <= `PMC_RST_POWER;
    else if (wr_en && addr_ff == `PMC_ADDR_POWER)
      power_ff <= nxt_byte;
  end

  // R08 proof force register
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      self_check_ff <= `PMC_RST_SELF_CHECK;
    else if (wr_en && addr_ff == `PMC_ADDR_SELF_CHECK)
      self_check_ff <= nxt_byte;
  end

  // Motion detection configuration and irq pin two map
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      motion_ff <= `PMC_RST_MOTION;
      irq2_map_ff <= `PMC_RST_IRQ2_MAP;
    end
    else if (wr_en && addr_ff == `PMC_ADDR_MOTION)
      motion_ff <= nxt_byte;
    else if (wr_en && addr_ff == `PMC_ADDR_IRQ2_MAP)
      irq2_map_ff <= nxt_byte;
  end

  // Internal timebase divider, one enable pulse per tick period
  always_ff @(posedge clk_sys)
  begin
    if (srst || tick_cnt_ff == TICK_LAST)
      tick_cnt_ff <= 8'h00;
    else
      tick_cnt_ff <= tick_cnt_ff + 8'h01;
  end
  assign int_tick = (tick_cnt_ff == TICK_LAST);

  // R01 timebase source select
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      tick_ff <= 1'b0;
    else
      tick_ff <= power_ff.outside_timebase_select ? ext_edge : int_tick;
  end
  assign timebase_tick_o = tick_ff;

  // R02 noise tradeoff passed to the core
  assign noise_mode_o = power_ff.noise;

  // R04 auto-doze gated by chained or repeat-cycle detection
  assign doze_eff = power_ff.auto_doze &&
    (motion_ff[`PMC_LINK_HI:`PMC_LINK_LO] == `PMC_LINK_CHAINED ||
     motion_ff[`PMC_LINK_HI:`PMC_LINK_LO] == `PMC_LINK_REPEAT);

  // R03 R05 periodic wake, forced while dozing on inactivity
  assign periodic_wake_o = power_ff.periodic_wake_mode || (doze_eff && inactivity_i);

  // R06 only code 10 measures; reserved codes stay in standby
  assign run_select_o = (power_ff.run_select == PMC_RUN_RUN_SELECT);

  // R08 proof force follows the bit
  assign proof_force_o = self_check_ff[`PMC_PROOF_BIT];

  // R11 R12 awake routed to irq pin two; pin floats when unmapped
  // Runs straight from the status level so no host service is ever needed
  assign irq_pin_two_o = awake_status_i ^ irq2_map_ff[`PMC_MAP_LOW_BIT];
  assign irq_pin_two_oe = irq2_map_ff[`PMC_MAP_AWAKE_BIT];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  a_ext_timebase: assert property (power_ff.outside_timebase_select && $stable(power_ff) |=> // R01
    timebase_tick_o == $past(ext_edge)) else $error("tick not from outside timebase");
  a_int_timebase: assert property (!power_ff.outside_timebase_select && $stable(power_ff) |=> // R01
    timebase_tick_o == $past(int_tick)) else $error("tick not from internal divider");
  a_noise_map: assert property (wr_en && addr_ff == `PMC_ADDR_POWER |=> // R02
    noise_mode_o == $past(nxt_byte[5:4])) else $error("noise field not applied");
  a_wake_bit: assert property (power_ff.periodic_wake_mode |-> periodic_wake_o) // R03
    else $error("wake bit ignored");
  a_doze_ignored: assert property (!doze_eff |-> periodic_wake_o == power_ff.periodic_wake_mode) // R04
    else $error("auto-doze acted outside chained or repeat mode");
  a_doze_enter: assert property (power_ff.auto_doze && motion_ff[5:4] == 2'b11 && inactivity_i // R05
    |-> periodic_wake_o) else $error("no doze on inactivity");
  a_run_map: assert property (run_select_o == (power_ff[1:0] == 2'b10)) // R06
    else $error("run select decode wrong");
  a_reset_zero: assert property (@(posedge clk_sys) disable iff (1'b0) $past(srst) |-> // R07
    power_ff == 8'h00 && !run_select_o && !proof_force_o) else $error("power register not reset");
  a_proof_force: assert property (wr_en && addr_ff == `PMC_ADDR_SELF_CHECK |=> // R08
    proof_force_o == $past(nxt_byte[0])) else $error("proof force not applied");
  a_awake_pin: assert property (irq2_map_ff[6] |-> irq_pin_two_oe && // R11
    irq_pin_two_o == (awake_status_i ^ irq2_map_ff[7])) else $error("awake not on pin two");
  a_awake_map: assert property (wr_en && addr_ff == `PMC_ADDR_IRQ2_MAP |=> // R12
    irq_pin_two_oe == $past(nxt_byte[6])) else $error("awake map not applied");

  c_run_select_wake: cover property (power_ff == 8'h0a);
  c_ext_clock: cover property (power_ff.outside_timebase_select && timebase_tick_o);
  c_doze: cover property (doze_eff && inactivity_i && !power_ff.periodic_wake_mode);
  c_read: cover property (spi_miso_oe && sclk_fall);
endmodule

/* tb/pmc_host_model.sv */
// Host side model: sends command, address and data frames to the bank's serial pins.
// Assumes the caller enters frame() just after a rising edge of clk_sys.
module pmc_host_model (
  // Clock
  input wire logic clk_sys,
  // Serial register pins
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle pins at time zero
  initial
  begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // High sclk phase lasts 5 clocks and low phase 10, above the 4 the synchroniser needs
  // host sends only what it is told
  // dwell count lives outside this bank, so no frame ever writes it
  task automatic frame(input logic [7:0] cmd, input logic [7:0] adr, input logic [7:0] dat,
                       output logic [7:0] rdat);
    logic [23:0] bits;
    bits = {cmd, adr, dat};
    rdat = 8'h00;
    spi_cs_n <= 1'b0;
    for (int i = 0; i < 24; i++)
    begin
      repeat (5) @(posedge clk_sys);
      spi_mosi <= bits[23 - i];
      repeat (5) @(posedge clk_sys);
      spi_sclk <= 1'b1;
      rdat = {rdat[6:0], spi_miso}; // Sampled on the rising edge
      repeat (5) @(posedge clk_sys);
      spi_sclk <= 1'b0;
    end
    repeat (5) @(posedge clk_sys);
    spi_cs_n <= 1'b1;
    spi_mosi <= ~spi_mosi; // Released data line must not look held
    repeat (5) @(posedge clk_sys);
  endtask
endmodule

/* tb/pmc_power_mode_bank_test.sv */
// Testbench of the power mode bank: random and corner register frames, checked at the pins.
// Assumes the host model and the design package are compiled first.
module pmc_power_mode_bank_test;
  timeunit 1ns;
  timeprecision 1ns;
  import pmc_pkg::*;
  logic clk_sys = 1'b0, srst = 1'b1, irq_pin_one_i = 1'b0, inactivity_i = 1'b0, awake_status_i = 1'b0;
  logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, irq_pin_two_o, irq_pin_two_oe;
  logic timebase_tick_o, periodic_wake_o, run_select_o, proof_force_o;
  pmc_noise_e noise_mode_o;
  int mismatches = 0, checked = 0, cycles = 0, ticks = 0;
  logic [7:0] rd, pw, mp;
  pmc_power_mode_bank pmc_power_mode_bank_i (.clk_sys(clk_sys), .srst(srst), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .irq_pin_one_i(irq_pin_one_i), .irq_pin_two_o(irq_pin_two_o), .irq_pin_two_oe(irq_pin_two_oe),
    .inactivity_i(inactivity_i), .awake_status_i(awake_status_i), .timebase_tick_o(timebase_tick_o),
    .noise_mode_o(noise_mode_o), .periodic_wake_o(periodic_wake_o), .run_select_o(run_select_o),
    .proof_force_o(proof_force_o));
  pmc_host_model pmc_host_model_i (.clk_sys(clk_sys), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso));
  // Clock of 50 ns
  initial forever #25 clk_sys = ~clk_sys;
  // Ticks counted on the falling edge, away from the edge the bench reads them on
  always @(negedge clk_sys)
  begin
    if (timebase_tick_o === 1'b1) ticks++;
  end
  // Hang guard, well above the some 10500 cycles of the run
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      mismatches++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    pmc_host_model_i.frame(8'h01, adr, dat, rd);
    repeat (8) @(posedge clk_sys); // Let the commit reach the outputs
  endtask
  task automatic rdchk(input string name, input logic [7:0] adr, input logic [7:0] exp);
    pmc_host_model_i.frame(8'h02, adr, 8'h00, rd);
    chk(name, exp, rd);
  endtask
  // Wake level expected from power value, motion config and inactivity
  function automatic logic exp_wake(input logic [7:0] p, input logic [7:0] m, input logic ina);
    return p[3] | (p[2] & m[4] & ina);
  endfunction
  // Main sequence
  initial
  begin
    void'($urandom(32'hcf744b39));
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rdchk("power reset", 8'h2d, 8'h00);
    rdchk("self check reset", 8'h2e, 8'h00);
    chk("run_select reset", 8'h00, {7'h00, run_select_o});
    chk("noise reset", 8'h00, {6'h00, noise_mode_o});
    chk("miso oe idle", 8'h00, {7'h00, spi_miso_oe});
    $display("test reset done");
    for (int n = 0; n < 4; n++)
    begin
      pw = (n == 3) ? 8'h0a : {2'b00, n[1:0], 1'($urandom), 1'b0, 1'($urandom) & 1'b1, 1'b0};
      wr(8'h2d, pw);
      chk("noise", {6'h00, pw[5:4]}, {6'h00, noise_mode_o});
      chk("run_select", {7'h00, pw[1:0] == 2'b10}, {7'h00, run_select_o});
      chk("wake", {7'h00, pw[3]}, {7'h00, periodic_wake_o});
      rdchk("power readback", 8'h2d, pw);
    end
    $display("test modes done");
    for (int l = 0; l < 4; l++)
    begin
      mp = {2'b00, l[1:0], 4'h0};
      wr(8'h27, mp);
      wr(8'h2d, 8'h06);
      for (int a = 0; a < 2; a++)
      begin
        inactivity_i <= a[0];
        repeat (2) @(posedge clk_sys);
        chk("doze wake", {7'h00, exp_wake(8'h06, mp, a[0])}, {7'h00, periodic_wake_o});
      end
    end
    inactivity_i <= 1'b0;
    $display("test doze done");
    wr(8'h2e, 8'h01);
    repeat (3)
    begin
      repeat (20) @(posedge clk_sys);
      chk("proof on", 8'h01, {7'h00, proof_force_o});
    end
    rdchk("self check readback", 8'h2e, 8'h01);
    wr(8'h2e, 8'h00);
    chk("proof off", 8'h00, {7'h00, proof_force_o});
    $display("test proof done");
    for (int k = 0; k < 3; k++)
    begin
      mp = (k == 0) ? 8'h00 : ((k == 1) ? 8'h40 : 8'hc0);
      wr(8'h2b, mp);
      repeat (6)
      begin
        awake_status_i <= 1'($urandom);
        repeat (2) @(posedge clk_sys);
        chk("pin two oe", {7'h00, mp[6]}, {7'h00, irq_pin_two_oe});
        if (mp[6]) chk("pin two", {7'h00, awake_status_i ^ mp[7]}, {7'h00, irq_pin_two_o});
      end
    end
    $display("test awake pin done");
    wr(8'h2d, 8'h02);
    ticks = 0;
    repeat (200) @(posedge clk_sys);
    chk("internal ticks", 8'h0a, 8'(ticks));
    wr(8'h2d, 8'h42);
    ticks = 0;
    repeat (7)
    begin
      irq_pin_one_i <= 1'b1;
      repeat (6) @(posedge clk_sys);
      irq_pin_one_i <= 1'b0;
      repeat (6) @(posedge clk_sys);
    end
    repeat (6) @(posedge clk_sys);
    chk("outside ticks", 8'h07, 8'(ticks));
    rdchk("unmapped read", 8'h30, 8'h00);
    $display("test timebase done");
    conclude();
  end
endmodule
